// ===== rtl/csc_defs.svh
// constants of the clock switch controller
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH
`define CSC_ADDR_W 26
`define CSC_IDX_W 24
`define CSC_IDX_OSC 24'h000742
`define CSC_IDX_DIV 24'h000744
`define CSC_IDX_FBD 24'h000746
`define CSC_IDX_TUN 24'h000748
`define CSC_IDX_AUX 24'h00074A
`define CSC_IDX_SSC 24'hF80006
`define CSC_IDX_MOD 24'hF80008
`define CSC_RST_OSC 16'h7700
`define CSC_RST_DIV 16'h3040
`define CSC_RST_FBD 16'h0030
`define CSC_RST_TUN 16'h0000
`define CSC_RST_AUX 16'h0000
`define CSC_KEY_HI1 8'h78
`define CSC_KEY_HI2 8'h9A
`define CSC_KEY_LO1 8'h46
`define CSC_KEY_LO2 8'h57
`define CSC_B_REQ 0
`define CSC_B_SEC 1
`define CSC_B_CF 3
`define CSC_B_LOCK 5
`define CSC_B_FRZ 7
`define CSC_NEXT_LSB 8
`define CSC_NEXT_MSB 10
`define CSC_CUR_LSB 12
`define CSC_CUR_MSB 14
`define CSC_CFG_TS 7
`define CSC_CFG_INI_MSB 2
`define CSC_CFG_SW 7
`define CSC_CFG_MON 6
`define CSC_SRC_FRC 3'h0
`define CSC_SRC_FRCPLL 3'h1
`define CSC_SRC_POSC 3'h2
`define CSC_SRC_POSCPLL 3'h3
`define CSC_SRC_SOSC 3'h4
`define CSC_SRC_LPRC 3'h5
`define CSC_OSC_FRC 4'h1
`define CSC_OSC_POSC 4'h2
`define CSC_OSC_SOSC 4'h4
`define CSC_OSC_LPRC 4'h8
`define CSC_CLK_MHZ 10
`define CSC_OST_NS 102400
`define CSC_OST_CYC ((`CSC_OST_NS * `CSC_CLK_MHZ + 999) / 1000)
`define CSC_OST_W 11
`define CSC_BOOT_CYC 2'h3
`define CSC_SYNC_W 38
`define CSC_RESP_OK 2'h0
`define CSC_RESP_ERR 2'h2
`endif

// ===== rtl/csc_pkg.sv
// types of the clock switch controller
package csc_pkg;
    typedef enum logic [1:0] {st_boot, st_idle, st_start, st_wait}
        csc_state_t;
    typedef enum logic [1:0] {lk_idle, lk_first, lk_open} csc_unlock_t;
    typedef enum logic [2:0] {
        rg_osc, rg_div, rg_fbd, rg_tun, rg_aux, rg_ssc, rg_mod, rg_none
    } csc_reg_t;
endpackage

// ===== rtl/csc_top.sv
// clock switch controller with axi4-lite register slave
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "csc_defs.svh"

module csc_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [`CSC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [`CSC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // configuration words and oscillator status pins
    input wire logic [15:0] cfg_source_select,
    input wire logic [15:0] cfg_mode,
    input wire logic [3:0] osc_ready,
    input wire logic pll_lock,
    input wire logic sleep_instruction,
    // oscillator control
    output logic [3:0] osc_enable,
    output logic pll_enable,
    output logic [2:0] clk_select,
    output logic sleep_enter
);
    import csc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    function automatic csc_reg_t decode(input logic [`CSC_ADDR_W-1:0] a);
        logic [`CSC_IDX_W-1:0] idx;
        idx = a[`CSC_ADDR_W-1:2];
        case (idx)
            `CSC_IDX_OSC: decode = rg_osc;
            `CSC_IDX_DIV: decode = rg_div;
            `CSC_IDX_FBD: decode = rg_fbd;
            `CSC_IDX_TUN: decode = rg_tun;
            `CSC_IDX_AUX: decode = rg_aux;
            `CSC_IDX_SSC: decode = rg_ssc;
            `CSC_IDX_MOD: decode = rg_mod;
            default: decode = rg_none;
        endcase
    endfunction

    function automatic logic [3:0] src_osc(input logic [2:0] s);
        case (s)
            `CSC_SRC_POSC, `CSC_SRC_POSCPLL: src_osc = `CSC_OSC_POSC;
            `CSC_SRC_SOSC: src_osc = `CSC_OSC_SOSC;
            `CSC_SRC_LPRC: src_osc = `CSC_OSC_LPRC;
            default: src_osc = `CSC_OSC_FRC;
        endcase
    endfunction

    function automatic logic is_pll(input logic [2:0] s);
        is_pll = (s == `CSC_SRC_FRCPLL) || (s == `CSC_SRC_POSCPLL);
    endfunction

    function automatic logic is_xtal(input logic [2:0] s);
        is_xtal = (src_osc(s) == `CSC_OSC_POSC) ||
            (src_osc(s) == `CSC_OSC_SOSC);
    endfunction

    // sequence tracking for a byte that is not currently open
    function automatic csc_unlock_t lk_step(input csc_unlock_t st,
        input logic [7:0] d, input logic [7:0] k1, input logic [7:0] k2);
        if (st == lk_first && d == k2)
            lk_step = lk_open;
        else if (d == k1)
            lk_step = lk_first;
        else
            lk_step = lk_idle;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser; config words are treated as slow pins
    logic [`CSC_SYNC_W-1:0] sync_a_r;
    logic [`CSC_SYNC_W-1:0] sync_b_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a_r <= '0;
            sync_b_r <= '0;
        end else begin
            sync_a_r <= {cfg_source_select, cfg_mode, osc_ready, pll_lock,
                sleep_instruction};
            sync_b_r <= sync_a_r;
        end
    end

    logic [15:0] cfg_ss;
    logic [15:0] cfg_md;
    logic [3:0] rdy_s;
    logic lock_s;
    logic sleep_s;
    assign {cfg_ss, cfg_md, rdy_s, lock_s, sleep_s} = sync_b_r;

    logic sw_en;
    logic mon_en;
    assign sw_en = !cfg_md[`CSC_CFG_SW];
    assign mon_en = sw_en && !cfg_md[`CSC_CFG_MON];

    ////////////////////////////////////////////////////////////////////////
    // axi write channel: one write at a time
    logic aw_have_r;
    logic w_have_r;
    logic [`CSC_ADDR_W-1:0] awaddr_r;
    logic [15:0] wdata_r;
    logic [1:0] wstrb_r;
    logic wr_go;
    csc_reg_t wr_sel;
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_sel = decode(awaddr_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSC_RESP_OK;
        end else begin
            if (!aw_have_r && !s_axi_bvalid)
                s_axi_awready <= 1'b1;
            if (!w_have_r && !s_axi_bvalid)
                s_axi_wready <= 1'b1;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata[15:0];
                wstrb_r <= s_axi_wstrb[1:0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_sel == rg_none) ? `CSC_RESP_ERR :
                    `CSC_RESP_OK;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // plain storage registers, byte writable
    logic [15:0] plain_r [0:3];
    localparam csc_reg_t PLAIN_SEL [0:3] = '{rg_div, rg_fbd, rg_tun, rg_aux};
    localparam logic [15:0] PLAIN_RST [0:3] = '{`CSC_RST_DIV,
        `CSC_RST_FBD, `CSC_RST_TUN, `CSC_RST_AUX};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_plain
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    plain_r[gi] <= PLAIN_RST[gi];
                end else if (wr_go && wr_sel == PLAIN_SEL[gi]) begin
                    if (wstrb_r[1])
                        plain_r[gi][15:8] <= wdata_r[15:8];
                    if (wstrb_r[0])
                        plain_r[gi][7:0] <= wdata_r[7:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // osc_control fields, unlock tracking and switch sequencer
    // literals take no part-select, so the reset word gets a name
    localparam logic [15:0] OSC_RST = `CSC_RST_OSC;
    csc_state_t state_r;
    csc_unlock_t lk_hi_r;
    csc_unlock_t lk_lo_r;
    logic [2:0] cur_r;
    logic [2:0] next_r;
    logic [2:0] tgt_r;
    logic req_r;
    logic freeze_r;
    logic cf_r;
    logic lockbit_r;
    logic sec_keep_r;
    logic ts_r;
    logic sleep_d_r;
    logic [1:0] boot_cnt_r;
    logic [`CSC_OST_W-1:0] ost_cnt_r;

    logic osc_wr;
    logic hi_wr;
    logic lo_wr;
    logic sleep_rise;
    logic ost_done;
    logic tgt_ready;
    logic req_ok;
    assign osc_wr = wr_go && wr_sel == rg_osc;
    assign hi_wr = osc_wr && wstrb_r[1];
    assign lo_wr = osc_wr && wstrb_r[0];
    assign sleep_rise = sleep_s && !sleep_d_r;
    assign ost_done = ost_cnt_r == `CSC_OST_W'(`CSC_OST_CYC);
    // frozen requests only refused in the switching-without-monitor mode
    assign req_ok = sw_en && !(freeze_r && !mon_en);
    assign tgt_ready = |(rdy_s & src_osc(tgt_r)) &&
        (!is_xtal(tgt_r) || ost_done) &&
        (!is_pll(tgt_r) || lock_s);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= st_boot;
            lk_hi_r <= lk_idle;
            lk_lo_r <= lk_idle;
            {cur_r, next_r} <= {OSC_RST[`CSC_CUR_MSB:`CSC_CUR_LSB],
                OSC_RST[`CSC_NEXT_MSB:`CSC_NEXT_LSB]};
            tgt_r <= `CSC_SRC_FRC;
            req_r <= 1'b0;
            freeze_r <= 1'b0;
            cf_r <= 1'b0;
            lockbit_r <= 1'b0;
            sec_keep_r <= 1'b0;
            ts_r <= 1'b0;
            sleep_d_r <= 1'b0;
            boot_cnt_r <= '0;
            ost_cnt_r <= '0;
        end else begin
            sleep_d_r <= sleep_s;
            if (is_pll(tgt_r) && state_r == st_wait)
                lockbit_r <= lock_s;
            case (state_r)
                st_boot: begin
                    // wait until the synchronised config words are valid
                    boot_cnt_r <= boot_cnt_r + 2'h1;
                    if (boot_cnt_r == `CSC_BOOT_CYC) begin
                        next_r <= cfg_ss[`CSC_CFG_INI_MSB:0];
                        if (cfg_ss[`CSC_CFG_TS] &&
                            cfg_ss[`CSC_CFG_INI_MSB:0] != `CSC_SRC_FRC) begin
                            cur_r <= `CSC_SRC_FRC;
                            tgt_r <= cfg_ss[`CSC_CFG_INI_MSB:0];
                            req_r <= 1'b1;
                            ts_r <= 1'b1;
                            ost_cnt_r <= '0;
                            state_r <= st_wait;
                        end else begin
                            cur_r <= cfg_ss[`CSC_CFG_INI_MSB:0];
                            state_r <= st_idle;
                        end
                    end
                end
                st_idle: begin
                    if (req_r)
                        state_r <= st_start;
                end
                st_start: begin
                    ost_cnt_r <= '0;
                    if (!req_r) begin
                        state_r <= st_idle;
                    end else if (next_r == cur_r) begin
                        req_r <= 1'b0;
                        state_r <= st_idle;
                    end else begin
                        lockbit_r <= 1'b0;
                        cf_r <= 1'b0;
                        tgt_r <= next_r;
                        state_r <= st_wait;
                    end
                end
                st_wait: begin
                    if (is_xtal(tgt_r) && !ost_done)
                        ost_cnt_r <= ost_cnt_r + `CSC_OST_W'(1);
                    if (!ts_r && sleep_rise) begin
                        req_r <= 1'b0;
                        state_r <= st_idle;
                    end else if (!req_r) begin
                        state_r <= st_idle;
                    end else if (!ts_r && next_r != tgt_r) begin
                        state_r <= st_start;
                    end else if (tgt_ready) begin
                        cur_r <= tgt_r;
                        req_r <= 1'b0;
                        ts_r <= 1'b0;
                        state_r <= st_idle;
                    end
                    // no ready source: simply stay here
                end
                default: state_r <= st_idle;
            endcase
            if (state_r != st_wait)
                ost_cnt_r <= '0;

            // upper byte: source selection behind its own key pair
            if (hi_wr) begin
                if (lk_hi_r == lk_open) begin
                    lk_hi_r <= lk_idle;
                    if (!ts_r)
                        next_r <= wdata_r[`CSC_NEXT_MSB:`CSC_NEXT_LSB];
                end else begin
                    lk_hi_r <= lk_step(lk_hi_r, wdata_r[15:8],
                        `CSC_KEY_HI1, `CSC_KEY_HI2);
                end
            end else if (wr_go) begin
                lk_hi_r <= lk_idle;
            end

            // lower byte; a software write here wins over a hw clear
            if (lo_wr) begin
                if (lk_lo_r == lk_open) begin
                    lk_lo_r <= lk_idle;
                    freeze_r <= freeze_r | wdata_r[`CSC_B_FRZ];
                    cf_r <= wdata_r[`CSC_B_CF];
                    sec_keep_r <= wdata_r[`CSC_B_SEC];
                    if (!ts_r) begin
                        if (!wdata_r[`CSC_B_REQ])
                            req_r <= 1'b0;
                        else if (req_ok)
                            req_r <= 1'b1;
                    end
                end else begin
                    lk_lo_r <= lk_step(lk_lo_r, wdata_r[7:0],
                        `CSC_KEY_LO1, `CSC_KEY_LO2);
                end
            end else if (wr_go) begin
                lk_lo_r <= lk_idle;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator drive; make-before-break keeps old and new running
    logic switching;
    assign switching = state_r == st_wait;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_enable <= `CSC_OSC_FRC;
            pll_enable <= 1'b0;
            clk_select <= `CSC_SRC_FRC;
            sleep_enter <= 1'b0;
        end else begin
            osc_enable <= src_osc(cur_r) |
                (switching ? src_osc(tgt_r) : 4'h0) |
                (mon_en ? `CSC_OSC_FRC : 4'h0) |
                (sec_keep_r ? `CSC_OSC_SOSC : 4'h0);
            pll_enable <= is_pll(cur_r) ||
                (switching && is_pll(tgt_r));
            clk_select <= cur_r;
            sleep_enter <= sleep_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read channel
    logic [15:0] osc_word;
    assign osc_word = {1'b0, cur_r, 1'b0, next_r, freeze_r, 1'b0,
        lockbit_r, 1'b0, cf_r, 1'b0, sec_keep_r, req_r};

    function automatic logic [15:0] rd_mux(input csc_reg_t s,
        input logic [15:0] ow, input logic [15:0] ss,
        input logic [15:0] md);
        case (s)
            rg_osc: rd_mux = ow;
            rg_div: rd_mux = plain_r[0];
            rg_fbd: rd_mux = plain_r[1];
            rg_tun: rd_mux = plain_r[2];
            rg_aux: rd_mux = plain_r[3];
            rg_ssc: rd_mux = ss;
            rg_mod: rd_mux = md;
            default: rd_mux = 16'h0000;
        endcase
    endfunction

    csc_reg_t rd_sel;
    assign rd_sel = decode(s_axi_araddr);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `CSC_RESP_OK;
        end else begin
            if (!s_axi_rvalid && !s_axi_arready)
                s_axi_arready <= 1'b1;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {16'h0000,
                    rd_mux(rd_sel, osc_word, cfg_ss, cfg_md)};
                s_axi_rresp <= (rd_sel == rg_none) ? `CSC_RESP_ERR :
                    `CSC_RESP_OK;
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ===== tb/csc_top_chk.sv
// assertion checker for the clock switch controller
`timescale 1ns/100ps
module csc_top_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // oscillator pins
    input wire logic [3:0] osc_ready,
    input wire logic pll_lock,
    input wire logic sleep_instruction,
    input wire logic [3:0] osc_enable,
    input wire logic [2:0] clk_select,
    input wire logic sleep_enter
);
    // a little slack below 1024 for the output register lag
    localparam int OST_MIN = 1020;
    logic [10:0] pri_on_r;
    logic [10:0] sec_on_r;

    function automatic logic [3:0] src_bit(input logic [2:0] s);
        case (s)
            3'h2, 3'h3: src_bit = 4'h2;
            3'h4: src_bit = 4'h4;
            3'h5: src_bit = 4'h8;
            default: src_bit = 4'h1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // saturating on-time of each crystal enable
    always_ff @(posedge aclk) begin
        if (!aresetn || !osc_enable[1]) begin
            pri_on_r <= 11'h000;
        end else if (pri_on_r != 11'h7FF) begin
            pri_on_r <= pri_on_r + 11'h001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !osc_enable[2]) begin
            sec_on_r <= 11'h000;
        end else if (sec_on_r != 11'h7FF) begin
            sec_on_r <= sec_on_r + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    // boot load may move the selection without a switch
    sequence s_src_move;
        $changed(clk_select) && $past(aresetn);
    endsequence

    AST_SRC_ON: assert property (|(src_bit(clk_select) & osc_enable))
        else $error("running source not enabled");
    AST_SRC_READY: assert property (
        s_src_move |-> |(src_bit(clk_select) & $past(osc_ready, 3)))
        else $error("switched to a source that was not ready");
    AST_PLL_LOCK: assert property (
        s_src_move ##0 (clk_select inside {3'h1, 3'h3}) |->
        $past(pll_lock, 3))
        else $error("switched to pll source without lock");
    AST_XTAL_PRI: assert property (
        s_src_move ##0 (clk_select inside {3'h2, 3'h3}) |->
        pri_on_r >= OST_MIN)
        else $error("primary switch before start timer");
    AST_XTAL_SEC: assert property (
        s_src_move ##0 (clk_select == 3'h4) |-> sec_on_r >= OST_MIN)
        else $error("secondary switch before start timer");
    AST_SLEEP_PULSE: assert property (
        $rose(sleep_instruction) |-> ##[1:4] sleep_enter)
        else $error("sleep not passed on");
    // response registered one cycle after the taken pair is held
    AST_WR_ANSWER: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_RD_ANSWER: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
endmodule

bind csc_top csc_top_chk i_csc_top_chk (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .osc_ready(osc_ready), .pll_lock(pll_lock),
    .sleep_instruction(sleep_instruction), .osc_enable(osc_enable),
    .clk_select(clk_select), .sleep_enter(sleep_enter)
);

// ===== tb/testbench.sv
// self-checking bench for the clock switch controller
`timescale 1ns/100ps
module testbench;
    localparam logic [25:0] OSC = 26'h0001D08;
    localparam logic [1:0] OK = 2'h0;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [25:0] awaddr = 26'h0;
    logic [25:0] araddr = 26'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [15:0] cfg_ss = 16'h0082;
    logic [15:0] cfg_md = 16'h0040;
    logic [3:0] osc_ready = 4'hF;
    logic pll_lock = 1'b1, sleep_in = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sleep_enter, pll_enable;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] osc_enable;
    logic [2:0] clk_select, n;
    logic [15:0] r;
    logic [15:0] rv [4] = '{16'h3040, 16'h0030, 16'h0000, 16'h0000};
    int errors = 0, checks_done = 0, cycles = 0, seed = 29880, base;

    csc_top i_csc_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cfg_source_select(cfg_ss), .cfg_mode(cfg_md),
        .osc_ready(osc_ready), .pll_lock(pll_lock),
        .sleep_instruction(sleep_in), .osc_enable(osc_enable),
        .pll_enable(pll_enable), .clk_select(clk_select),
        .sleep_enter(sleep_enter)
    );

    always #50 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // four or five crystal handovers dominate the run
    always @(posedge aclk) begin
        cycles++;
        if (cycles > 30000) begin
            errors++;
            stop_test();
        end
    end

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask

    function automatic logic [15:0] fx(input logic [2:0] c,
        input logic [2:0] x, input logic q);
        fx = {1'b0, c, 1'b0, x, 7'h00, q};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [25:0] a, input logic [15:0] d,
        input logic [3:0] s, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({14'h0, bresp}, {14'h0, er});
    endtask

    task automatic rd(input logic [25:0] a, output logic [15:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata[15:0];
        rready <= 1'b0;
        chk({14'h0, rresp}, a == 26'h1D0C ? 16'h0002 : 16'h0000);
    endtask

    task automatic ul(input logic hi, input logic [7:0] v);
        logic [3:0] s;
        s = hi ? 4'h2 : 4'h1;
        wr(OSC, hi ? 16'h7800 : 16'h0046, s, OK);
        wr(OSC, hi ? 16'h9A00 : 16'h0057, s, OK);
        wr(OSC, hi ? {v, 8'h00} : {8'h00, v}, s, OK);
    endtask

    task automatic co(input logic [2:0] c, input logic [2:0] x,
        input logic q);
        logic [15:0] d;
        rd(OSC, d);
        chk(d & 16'h7701, fx(c, x, q));
    endtask

    // bounded poll of the request bit
    task automatic poll();
        logic [15:0] d;
        int i;
        i = 0;
        do begin
            rd(OSC, d);
            i++;
        end while (d[0] && i < 400);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
        co(3'h0, 3'h2, 1'b1);
        for (int i = 0; i < 4; i++) begin
            rd(26'h1D10 + 26'(8 * i), r);
            chk(r, rv[i]);
        end
        ul(1'b1, 8'h05);
        co(3'h0, 3'h2, 1'b1);
        poll();
        co(3'h2, 3'h2, 1'b0);
        chk({12'h0, osc_enable}, 16'h0002);
        base = $unsigned($random(seed)) % 6;
        for (int i = 0; i < 6; i++) begin
            n = 3'((base + i) % 6);
            ul(1'b1, {5'h00, n});
            ul(1'b0, 8'h01);
            poll();
            co(n, n, 1'b0);
            chk({13'h0, clk_select}, {13'h0, n});
        end
        ul(1'b0, 8'h01);
        poll();
        co(n, n, 1'b0);
        ul(1'b1, 8'h00);
        ul(1'b0, 8'h01);
        poll();
        for (int i = 0; i < 3; i++) begin
            wr(OSC, i == 1 ? 16'h9A00 : 16'h7800, 4'h2, OK);
            r = {8'($random(seed)) | 8'h01, 8'h00};
            wr(OSC, i == 0 ? r : i == 1 ? 16'h7800 : 16'h0057,
                i == 2 ? 4'h1 : 4'h2, OK);
            wr(OSC, 16'h0500, 4'h2, OK);
            co(3'h0, 3'h0, 1'b0);
        end
        ul(1'b1, 8'h05);
        wr(OSC, 16'h0400, 4'h2, OK);
        co(3'h0, 3'h5, 1'b0);
        osc_ready <= 4'h7;
        ul(1'b0, 8'h01);
        repeat (60) @(posedge aclk);
        co(3'h0, 3'h5, 1'b1);
        chk({13'h0, clk_select}, 16'h0000);
        ul(1'b1, 8'h04);
        poll();
        co(3'h4, 3'h4, 1'b0);
        ul(1'b1, 8'h05);
        ul(1'b0, 8'h01);
        repeat (30) @(posedge aclk);
        ul(1'b0, 8'h00);
        co(3'h4, 3'h5, 1'b0);
        chk({12'h0, osc_enable}, 16'h0004);
        pll_lock <= 1'b0;
        ul(1'b1, 8'h01);
        ul(1'b0, 8'h01);
        repeat (40) @(posedge aclk);
        rd(OSC, r);
        chk(r & 16'h7721, fx(3'h4, 3'h1, 1'b1));
        ul(1'b0, 8'h00);
        repeat (4) @(posedge aclk);
        chk({15'h0, pll_enable}, 16'h0000);
        ul(1'b0, 8'h01);
        pll_lock <= 1'b1;
        poll();
        co(3'h1, 3'h1, 1'b0);
        ul(1'b1, 8'h05);
        ul(1'b0, 8'h01);
        repeat (10) @(posedge aclk);
        sleep_in <= 1'b1;
        repeat (6) @(posedge aclk);
        sleep_in <= 1'b0;
        repeat (6) @(posedge aclk);
        co(3'h1, 3'h5, 1'b0);
        chk({13'h0, clk_select}, 16'h0001);
        wr(26'h1D0C, 16'h1234, 4'h3, 2'h2);
        rd(26'h1D0C, r);
        chk(r, 16'h0000);
        ul(1'b0, 8'h80);
        rd(OSC, r);
        chk(r & 16'h0080, 16'h0080);
        ul(1'b1, 8'h00);
        ul(1'b0, 8'h01);
        repeat (20) @(posedge aclk);
        co(3'h1, 3'h0, 1'b0);
        // switching off, so only the hardware handover may move
        cfg_ss <= 16'h0085;
        cfg_md <= 16'h00C0;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(OSC, r);
        chk(r & 16'h0080, 16'h0000);
        co(3'h0, 3'h5, 1'b1);
        // low-power rc held off until here so the handover is visible
        osc_ready <= 4'hF;
        poll();
        co(3'h5, 3'h5, 1'b0);
        ul(1'b1, 8'h00);
        ul(1'b0, 8'h01);
        repeat (20) @(posedge aclk);
        co(3'h5, 3'h0, 1'b0);
        stop_test();
    end
endmodule
